// *** inc/fdc_pkg.sv ***
package fdc_pkg;
   // register indices on the plain port
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_STAT = 3'h1;
   localparam logic [2:0] REG_TXD  = 3'h2;
   localparam logic [2:0] REG_RXD  = 3'h3;
   localparam logic [2:0] REG_IRQ  = 3'h4;
   localparam logic [2:0] REG_MASK = 3'h5;
   localparam logic [2:0] REG_SEL  = 3'h6;
   // control register fields
   localparam int CTL_DIR   = 0;
   localparam int CTL_STEP  = 1;
   localparam int CTL_READ  = 2;
   localparam int CTL_WRITE = 3;
   localparam int CTL_CRC   = 4;
   // status register fields
   localparam int ST_READY  = 0;
   localparam int ST_TRK0   = 1;
   localparam int ST_SECT   = 2;
   localparam int ST_LOCK   = 3;
   localparam int ST_MIS    = 4;
   localparam int ST_RXFULL = 5;
   localparam int ST_TXEMPT = 6;
   localparam int ST_BUSY   = 7;
   // interrupt status and mask fields
   localparam int IRQ_RX   = 0;
   localparam int IRQ_TX   = 1;
   localparam int IRQ_SECT = 2;
   localparam int IRQ_CRC  = 3;
   localparam int IRQ_W    = 4;
   // reset values and sizes
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [3:0]  SEL_RST    = 4'h0;
   localparam logic [3:0]  MASK_RST   = 4'h0;
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [3:0]  BYTE_LAST  = 4'h7;
   localparam logic [3:0]  CRC_LAST   = 4'hF;
   localparam int          SYNC_N     = 6;
   // serializer states
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_DATA = 3'b010,
      W_CRC  = 3'b100
   } fdc_wst_e;
endpackage

// *** verilog/fdc_crc16.sv ***
`timescale 1ns/10ps
`default_nettype none
module fdc_crc16 (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   // bit stream
   input  wire logic        init,
   input  wire logic        step,
   input  wire logic        bit_in,
   // running check word
   output logic [15:0]      crc
);
   logic [15:0] crc_q;
   logic [15:0] crc_d;
   logic        fb;

   // msb first; feeding the stored word back leaves zero
   assign fb    = crc_q[15] ^ bit_in;
   assign crc_d = init ? fdc_pkg::CRC_PRESET :
                  step ? ({crc_q[14:0], 1'b0} ^ (fb ? fdc_pkg::CRC_POLY : 16'h0000)) : crc_q;
   assign crc   = crc_q;

   // one shift per accepted bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crc_q <= fdc_pkg::CRC_PRESET;
      end else if (ce) begin
         crc_q <= crc_d;
      end
   end
endmodule
`default_nettype wire

// *** verilog/fdc_fm_path.sv ***
// Contract
// - on write, compute 16-bit check word and send it right after data
// - on read, recompute check word over data and recorded check word
// - a check mismatch sets a flag the host reads
// - write emits a clock half before each data half; read splits them
// - bytes serialize for writing and deserialize on reading
// - ready, outer cylinder, sector pulse, locked, mismatch readable as status
// - host drives direction, step, four select lines, read, write, check gate
// - select lines let up to sixteen drives attach
// - check word runs during both read and write
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fdc_fm_path #(
   parameter int SEL_W = 4
) (
   // clock, reset, enable
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   // register port
   input  wire logic [2:0]       addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic [7:0]            rdata,
   // drive status pins
   input  wire logic             drv_ready,
   input  wire logic             drv_track0,
   input  wire logic             sector_pulse_sense,
   input  wire logic             drv_locked,
   // serial link
   input  wire logic             link_clk,
   input  wire logic             fm_rd,
   output logic                  fm_wr,
   // drive control pins
   output logic                  seek_dir,
   output logic                  head_step,
   output logic [SEL_W-1:0]      drive_sel,
   output logic                  rd_gate,
   output logic                  wr_gate,
   output logic                  crc_gate,
   // interrupt
   output logic                  irq
);
   // the logic is sized for exactly four select lines
   if (SEL_W != 4) begin : g_chk
      $error("SEL_W must be 4");
   end

   // register hit decode, used for both strobes
   function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
      return a == r;
   endfunction

   logic [7:0]             ctrl_q;
   logic [SEL_W-1:0]       sel_q;
   logic [fdc_pkg::IRQ_W-1:0] mask_q;
   logic [fdc_pkg::IRQ_W-1:0] ist_q;
   logic [fdc_pkg::IRQ_W-1:0] ist_d;
   logic [fdc_pkg::IRQ_W-1:0] ev;
   logic [7:0]             txd_q;
   logic                   tx_full_q;
   logic [7:0]             rxd_q;
   logic                   rx_full_q;
   logic                   mis_q;
   logic [7:0]             rdata_q;
   logic [7:0]             rd_mux;
   logic [7:0]             stat;
   logic [fdc_pkg::SYNC_N-1:0] s1_q;
   logic [fdc_pkg::SYNC_N-1:0] s2_q;
   logic [fdc_pkg::SYNC_N-1:0] pins;
   logic                   lnk_q;
   logic                   sect_q;
   logic                   crc_en_q;
   logic                   rd_act_q;
   logic                   tick;
   logic                   sect_rise;
   logic                   rd_act;
   logic                   wr_act;
   logic                   crc_rise;
   logic                   crc_fall;
   logic                   rd_start;
   logic                   wr_ctrl;
   logic                   wr_sel;
   logic                   wr_txd;
   logic                   wr_mask;
   logic                   rd_rxd;
   logic                   rd_irq;
   // serializer
   fdc_pkg::fdc_wst_e      wst_q;
   fdc_pkg::fdc_wst_e      wst_d;
   logic [15:0]            wsh_q;
   logic [3:0]             wcnt_q;
   logic                   wph_q;
   logic                   snap_q;
   logic                   fm_wr_q;
   logic                   w_tick;
   logic                   w_last;
   logic                   tx_ld;
   logic                   w_step;
   // deserializer
   logic [7:0]             rsh_q;
   logic [3:0]             rcnt_q;
   logic                   rph_q;
   logic                   seen_q;
   logic                   rbit;
   logic                   r_stb;
   logic                   rx_done;
   // check word
   logic [15:0]            crc;
   logic                   crc_step;
   logic                   crc_bit;
   logic                   mis_set;

   // two flops per pin; only the second stage is read
   assign pins = {link_clk, fm_rd, drv_locked, sector_pulse_sense, drv_track0, drv_ready};
   for (genvar i = 0; i < fdc_pkg::SYNC_N; i++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
         end else if (ce) begin
            s1_q[i] <= pins[i];
            s2_q[i] <= s1_q[i];
         end
      end
   end

   // strobe decode
   assign wr_ctrl = wr & hit(addr, fdc_pkg::REG_CTRL);
   assign wr_sel  = wr & hit(addr, fdc_pkg::REG_SEL);
   assign wr_txd  = wr & hit(addr, fdc_pkg::REG_TXD);
   assign wr_mask = wr & hit(addr, fdc_pkg::REG_MASK);
   assign rd_rxd  = rd & hit(addr, fdc_pkg::REG_RXD);
   assign rd_irq  = rd & hit(addr, fdc_pkg::REG_IRQ);

   // edges of link clock, sector pulse and gates
   assign tick      = s2_q[5] & ~lnk_q;
   assign sect_rise = s2_q[2] & ~sect_q;
   assign rd_act    = ctrl_q[fdc_pkg::CTL_READ] & ~ctrl_q[fdc_pkg::CTL_WRITE];
   assign wr_act    = ctrl_q[fdc_pkg::CTL_WRITE];
   assign crc_rise  = ctrl_q[fdc_pkg::CTL_CRC] & ~crc_en_q;
   assign crc_fall  = ~ctrl_q[fdc_pkg::CTL_CRC] & crc_en_q;
   assign rd_start  = rd_act & ~rd_act_q;

   // host-written control and drive choice
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q <= fdc_pkg::CTRL_RST;
         sel_q  <= fdc_pkg::SEL_RST;
         mask_q <= fdc_pkg::MASK_RST;
      end else if (ce) begin
         if (wr_ctrl) ctrl_q <= wdata;
         if (wr_sel) sel_q <= wdata[SEL_W-1:0];
         if (wr_mask) mask_q <= wdata[fdc_pkg::IRQ_W-1:0];
      end
   end

   // direct pin drive; a decoder outside forms sixteen selects
   assign seek_dir  = ctrl_q[fdc_pkg::CTL_DIR];
   assign head_step = ctrl_q[fdc_pkg::CTL_STEP];
   assign drive_sel = sel_q;
   assign rd_gate   = ctrl_q[fdc_pkg::CTL_READ];
   assign wr_gate   = ctrl_q[fdc_pkg::CTL_WRITE];
   assign crc_gate  = ctrl_q[fdc_pkg::CTL_CRC];

   // edge history
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lnk_q    <= 1'b0;
         sect_q   <= 1'b0;
         crc_en_q <= 1'b0;
         rd_act_q <= 1'b0;
      end else if (ce) begin
         lnk_q    <= s2_q[5];
         sect_q   <= s2_q[2];
         crc_en_q <= ctrl_q[fdc_pkg::CTL_CRC];
         rd_act_q <= rd_act;
      end
   end

   // serializer control terms
   assign w_tick = tick & wr_act;
   assign w_last = w_tick & wph_q & (wcnt_q == 4'h0);
   assign tx_ld  = tx_full_q & ((w_tick & (wst_q == fdc_pkg::W_IDLE)) |
                               (w_last & (wst_q == fdc_pkg::W_DATA)));
   assign w_step = w_tick & wph_q & (wst_q == fdc_pkg::W_DATA) & crc_en_q;

   // next state; check word follows the last byte directly
   always_comb begin
      wst_d = wst_q;
      case (wst_q)
         fdc_pkg::W_IDLE: begin
            if (tx_ld) wst_d = fdc_pkg::W_DATA;
         end
         fdc_pkg::W_DATA: begin
            if (w_last & ~tx_full_q) wst_d = crc_en_q ? fdc_pkg::W_CRC : fdc_pkg::W_IDLE;
         end
         fdc_pkg::W_CRC: begin
            if (w_last) wst_d = fdc_pkg::W_IDLE;
         end
         default: wst_d = fdc_pkg::W_IDLE;
      endcase
      if (!wr_act) wst_d = fdc_pkg::W_IDLE;
   end

   // cell generator: clock half high, then data half
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wst_q   <= fdc_pkg::W_IDLE;
         wsh_q   <= 16'h0000;
         wcnt_q  <= 4'h0;
         wph_q   <= 1'b0;
         snap_q  <= 1'b0;
         fm_wr_q <= 1'b0;
      end else if (ce) begin
         wst_q <= wst_d;
         if (!wr_act) begin
            fm_wr_q <= 1'b0;
            wph_q   <= 1'b0;
         end else if (tx_ld) begin
            wsh_q  <= {txd_q, 8'h00};
            wcnt_q <= fdc_pkg::BYTE_LAST;
            wph_q  <= 1'b0;
            if (wst_q == fdc_pkg::W_IDLE) fm_wr_q <= 1'b0;
            else fm_wr_q <= wsh_q[15];
         end else if (w_tick & (wst_q != fdc_pkg::W_IDLE)) begin
            wph_q <= ~wph_q;
            if (!wph_q) begin
               fm_wr_q <= 1'b1;
               // the word is taken one half late, after its last update
               if (snap_q) wsh_q <= crc;
               snap_q <= 1'b0;
            end else begin
               fm_wr_q <= wsh_q[15];
               wsh_q   <= {wsh_q[14:0], 1'b0};
               wcnt_q  <= wcnt_q - 4'h1;
               if (w_last & (wst_d == fdc_pkg::W_CRC)) begin
                  wcnt_q <= fdc_pkg::CRC_LAST;
                  snap_q <= 1'b1;
               end
            end
         end else if (w_tick) begin
            fm_wr_q <= 1'b0;
         end
      end
   end
   assign fm_wr = fm_wr_q;

   // deserializer: a pulse in the data half is a one
   assign rbit    = seen_q | s2_q[4];
   assign r_stb   = tick & rd_act & rph_q;
   assign rx_done = r_stb & (rcnt_q == fdc_pkg::BYTE_LAST);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsh_q  <= 8'h00;
         rcnt_q <= 4'h0;
         rph_q  <= 1'b0;
         seen_q <= 1'b0;
      end else if (ce) begin
         if (rd_start) begin
            rcnt_q <= 4'h0;
            rph_q  <= 1'b0;
            seen_q <= 1'b0;
         end else if (tick & rd_act) begin
            rph_q  <= ~rph_q;
            seen_q <= 1'b0;
            if (rph_q) begin
               rsh_q  <= {rsh_q[6:0], rbit};
               rcnt_q <= rx_done ? 4'h0 : rcnt_q + 4'h1;
            end
         end else begin
            seen_q <= rbit;
         end
      end
   end

   // host holding registers; on both full flags a set beats a clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         txd_q     <= 8'h00;
         tx_full_q <= 1'b0;
         rxd_q     <= 8'h00;
         rx_full_q <= 1'b0;
      end else if (ce) begin
         if (wr_txd) txd_q <= wdata;
         tx_full_q <= wr_txd | (tx_full_q & ~tx_ld);
         if (rx_done) rxd_q <= {rsh_q[6:0], rbit};
         rx_full_q <= rx_done | (rx_full_q & ~rd_rxd);
      end
   end

   // check word engine shared by both directions
   assign crc_step = w_step | (r_stb & crc_en_q);
   assign crc_bit  = wr_act ? wsh_q[15] : rbit;
   fdc_crc16 u_crc (
      .clock  (clock),
      .rst    (rst),
      .ce     (ce),
      .init   (crc_rise),
      .step   (crc_step),
      .bit_in (crc_bit),
      .crc    (crc)
   );

   // residue checked when the host drops the gate after the stored word
   assign mis_set = crc_fall & rd_act & (crc != 16'h0000);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mis_q <= 1'b0;
      end else if (ce) begin
         if (mis_set) mis_q <= 1'b1;
         else if (crc_rise & rd_act) mis_q <= 1'b0;
      end
   end

   // sticky events, cleared by reading them
   assign ev    = {mis_set, sect_rise, tx_ld, rx_done};
   assign ist_d = ev | (ist_q & ~{fdc_pkg::IRQ_W{rd_irq}});
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ist_q <= '0;
      end else if (ce) begin
         ist_q <= ist_d;
      end
   end
   assign irq = |(ist_q & mask_q);

   // status and read mux
   assign stat = {wst_q != fdc_pkg::W_IDLE, ~tx_full_q, rx_full_q, mis_q,
                  s2_q[3], s2_q[2], s2_q[1], s2_q[0]};
   assign rd_mux = hit(addr, fdc_pkg::REG_CTRL) ? ctrl_q :
                   hit(addr, fdc_pkg::REG_STAT) ? stat :
                   hit(addr, fdc_pkg::REG_TXD)  ? txd_q :
                   hit(addr, fdc_pkg::REG_RXD)  ? rxd_q :
                   hit(addr, fdc_pkg::REG_IRQ)  ? {4'h0, ist_q} :
                   hit(addr, fdc_pkg::REG_MASK) ? {4'h0, mask_q} :
                   hit(addr, fdc_pkg::REG_SEL)  ? {4'h0, sel_q} : 8'h00;
   // data stand one cycle only, zero otherwise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         rdata_q <= rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_wr_clk_half;
      ce && w_tick && !wph_q && wst_q != fdc_pkg::W_IDLE && !tx_ld;
   endsequence
   sequence s_data_end_empty;
      ce && w_last && wst_q == fdc_pkg::W_DATA && !tx_full_q && crc_en_q;
   endsequence

   a_clock_half_high: assert property (s_wr_clk_half |=> fm_wr)
      else $error("clock half not driven high");
   a_crc_appended: assert property (s_data_end_empty |=> wst_q == fdc_pkg::W_CRC && wcnt_q == 4'hF)
      else $error("check word not appended");
   a_crc_snapshot: assert property (ce && snap_q && w_tick && !wph_q |=> wsh_q == $past(crc))
      else $error("check word not loaded");
   a_crc_runs_read: assert property (ce && r_stb && crc_en_q && !crc_rise |=>
      crc != $past(crc) || $past(crc[15]) == $past(rbit))
      else $error("check word idle on read");
   a_mismatch_flag: assert property (ce && mis_set |=> mis_q ##0 stat[fdc_pkg::ST_MIS])
      else $error("mismatch not flagged");
   a_mismatch_hold: assert property (mis_q && !(crc_rise && rd_act) |=> mis_q)
      else $error("mismatch flag lost");
   a_rx_byte_ready: assert property (ce && rx_done |=> rx_full_q && ist_q[fdc_pkg::IRQ_RX])
      else $error("byte not delivered");
   a_sel_follow: assert property (ce && wr_sel |=> drive_sel == $past(wdata[3:0]))
      else $error("select lines not updated");
   a_step_follow: assert property (ce && wr_ctrl |=> {rd_gate, head_step} == $past(wdata[2:1]))
      else $error("control pins not updated");
   a_status_pins: assert property (ce |=> stat[fdc_pkg::ST_READY] == $past(s1_q[0]))
      else $error("status not shown");
endmodule
`default_nettype wire

// *** testbench/fdc_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// drive-side stand-in; its half-cell clock only runs inside a frame
module fdc_drive_model (
   // serial link
   output logic      link_clk,
   output logic      fm_rd,
   input  wire logic fm_wr,
   // drive status pins
   output logic      drv_ready,
   output logic      drv_track0,
   output logic      sector_pulse_sense,
   output logic      drv_locked
);
   logic halves [0:63]; // fm_wr level seen as each half ends

   // quiet link, drive not ready
   initial begin
      link_clk = 1'b0;
      fm_rd = 1'b0;
      {drv_locked, sector_pulse_sense, drv_track0, drv_ready} = 4'h0;
   end

   // status pins change by nba, called just after a clock edge
   task automatic set_status(input logic [3:0] s);
      {drv_locked, sector_pulse_sense, drv_track0, drv_ready} <= s;
   endtask

   // one half cell: optional flux pulse mid-half, rising edge ends it
   task automatic one_half(input logic p);
      #63 fm_rd = p;
      #100 fm_rd = 1'b0;
      #37 link_clk = 1'b1;
      #200 link_clk = 1'b0;
   endtask

   // byte msb first, clock pulse before every data half
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         one_half(1'b1);
         one_half(b[i]);
      end
   endtask

   // run n halves while the block writes, record what it drove
   task automatic capture(input int n);
      for (int k = 0; k < n; k++) begin
         #213 link_clk = 1'b1;
         halves[k] = fm_wr;
         #187 link_clk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clock;
   logic       rst;
   logic       ce;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       link_clk, fm_rd, fm_wr, seek_dir, head_step, rd_gate, wr_gate, crc_gate, irq;
   logic       drv_ready, drv_track0, sector_pulse_sense, drv_locked;
   logic [3:0] drive_sel;
   int         bad_count;
   int         n_tests;

   fdc_fm_path #(.SEL_W(4)) DUT (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .drv_ready(drv_ready), .drv_track0(drv_track0),
      .sector_pulse_sense(sector_pulse_sense), .drv_locked(drv_locked), .link_clk(link_clk),
      .fm_rd(fm_rd), .fm_wr(fm_wr), .seek_dir(seek_dir), .head_step(head_step), .drive_sel(drive_sel),
      .rd_gate(rd_gate), .wr_gate(wr_gate), .crc_gate(crc_gate), .irq(irq));

   fdc_drive_model DRV (.link_clk(link_clk), .fm_rd(fm_rd), .fm_wr(fm_wr), .drv_ready(drv_ready),
      .drv_track0(drv_track0), .sector_pulse_sense(sector_pulse_sense), .drv_locked(drv_locked));

   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // register port: one-cycle strobes, read data in the following cycle
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask

   // bench's own check word, msb first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? fdc_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction

   // poll for a received byte; a hang ends the run
   task automatic wait_rx;
      logic [7:0] r;
      r = 8'h00;
      for (int k = 0; k < 400 && r[fdc_pkg::ST_RXFULL] !== 1'b1; k++) begin
         bus_rd(fdc_pkg::REG_STAT, r);
      end
      if (r[fdc_pkg::ST_RXFULL] !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end
   endtask

   task automatic t_ctrl;
      logic [7:0] r;
      check({irq, crc_gate, wr_gate, rd_gate, head_step, seek_dir, fm_wr, rdata[0]}, 8'h00);
      for (int i = 0; i < 5; i++) begin
         bus_wr(fdc_pkg::REG_CTRL, 8'h01 << i);
         @(posedge clock);
         check({3'h0, crc_gate, wr_gate, rd_gate, head_step, seek_dir}, 8'h01 << i);
      end
      bus_wr(fdc_pkg::REG_CTRL, 8'h00);
      for (int v = 0; v < 16; v++) begin
         bus_wr(fdc_pkg::REG_SEL, 8'(v));
         bus_rd(fdc_pkg::REG_SEL, r);
         check({4'h0, drive_sel}, 8'(v));
         check(r, 8'(v));
      end
      bus_wr(3'h7, 8'hFF);
      bus_rd(3'h7, r);
      check(r, 8'h00);
      $display("test ctrl done");
   endtask

   task automatic t_status;
      logic [7:0] r;
      DRV.set_status(4'h9);
      repeat (6) @(posedge clock);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(r & 8'h1F, 8'h09);
      bus_wr(fdc_pkg::REG_MASK, 8'h04);
      DRV.set_status(4'h6);
      repeat (6) @(posedge clock);
      check(8'(irq), 8'h01);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(r & 8'h1F, 8'h06);
      bus_rd(fdc_pkg::REG_IRQ, r);
      check(r, 8'h04);
      check(8'(irq), 8'h00);
      // masked event still lands in the sticky status
      bus_wr(fdc_pkg::REG_MASK, 8'h00);
      DRV.set_status(4'h9);
      repeat (6) @(posedge clock);
      DRV.set_status(4'hD);
      repeat (6) @(posedge clock);
      check(8'(irq), 8'h00);
      bus_rd(fdc_pkg::REG_IRQ, r);
      check(r, 8'h04);
      $display("test status done");
   endtask

   // host counts one track's sector pulses through the sticky status
   task automatic t_sectors;
      logic [7:0] r;
      int         n;
      n = 0;
      for (int i = 0; i < 32; i++) begin
         DRV.set_status(4'h9);
         repeat (4) @(posedge clock);
         DRV.set_status(4'hD);
         repeat (4) @(posedge clock);
         bus_rd(fdc_pkg::REG_IRQ, r);
         n += r[fdc_pkg::IRQ_SECT];
      end
      check(8'(n), 8'h20);
      $display("test sectors done");
   endtask

   // enable low freezes every flop; a second reset clears the pins again
   task automatic t_enable;
      logic [7:0] r;
      bus_wr(fdc_pkg::REG_SEL, 8'h05);
      ce <= 1'b0;
      bus_wr(fdc_pkg::REG_SEL, 8'h0A);
      DRV.set_status(4'h2);
      repeat (6) @(posedge clock);
      check({4'h0, drive_sel}, 8'h05);
      ce <= 1'b1;
      repeat (6) @(posedge clock);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(r & 8'h1F, 8'h02);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check({4'h0, drive_sel}, 8'h00);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(r & 8'h1F, 8'h02);
      $display("test enable done");
   endtask

   task automatic t_write(input logic [7:0] b);
      logic [15:0] c;
      logic [7:0]  r;
      int          s;
      c = crc_byte(fdc_pkg::CRC_PRESET, b);
      bus_wr(fdc_pkg::REG_MASK, 8'h02);
      bus_wr(fdc_pkg::REG_TXD, b);
      bus_wr(fdc_pkg::REG_CTRL, 8'h18);
      DRV.capture(56);
      s = 0;
      while (s < 6 && DRV.halves[s] !== 1'b1) s++;
      check(8'(s < 6), 8'h01);
      for (int i = 0; i < 24; i++) begin
         check(8'(DRV.halves[s+2*i]), 8'h01);
         check(8'(DRV.halves[s+2*i+1]), 8'(i < 8 ? b[7-i] : c[23-i]));
      end
      check(8'(DRV.halves[s+48]), 8'h00);
      check(8'(irq), 8'h01);
      bus_rd(fdc_pkg::REG_IRQ, r);
      check(r, 8'h02);
      bus_wr(fdc_pkg::REG_CTRL, 8'h00);
      $display("test write done");
   endtask

   // two data bytes plus check bytes; flip corrupts the recorded word
   task automatic t_read(input logic [15:0] flip, input logic held);
      logic [7:0]  d [4];
      logic [15:0] c;
      logic [7:0]  r;
      c = crc_byte(crc_byte(fdc_pkg::CRC_PRESET, 8'h3C), 8'hE1) ^ flip;
      d = '{8'h3C, 8'hE1, c[15:8], c[7:0]};
      bus_wr(fdc_pkg::REG_MASK, 8'h08);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(8'(r[fdc_pkg::ST_MIS]), 8'(held));
      bus_wr(fdc_pkg::REG_CTRL, 8'h14);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(8'(r[fdc_pkg::ST_MIS]), 8'h00);
      fork
         for (int i = 0; i < 4; i++) DRV.send_byte(d[i]);
         for (int i = 0; i < 4; i++) begin
            wait_rx();
            bus_rd(fdc_pkg::REG_RXD, r);
            check(r, d[i]);
         end
      join
      bus_wr(fdc_pkg::REG_CTRL, 8'h04);
      repeat (2) @(posedge clock);
      bus_rd(fdc_pkg::REG_STAT, r);
      check(8'(r[fdc_pkg::ST_MIS]), 8'(flip != 16'h0000));
      check(8'(irq), 8'(flip != 16'h0000));
      bus_rd(fdc_pkg::REG_IRQ, r);
      check(r & 8'h09, (flip != 16'h0000) ? 8'h09 : 8'h01);
      check(8'(irq), 8'h00);
      bus_wr(fdc_pkg::REG_CTRL, 8'h00);
      $display("test read done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      bad_count = 0;
      n_tests = 0;
      rst = 1'b1;
      ce = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_ctrl();
      t_status();
      t_sectors();
      t_write(8'hA5);
      t_read(16'h0000, 1'b0);
      t_read(16'h0001, 1'b0);
      t_read(16'h0000, 1'b1);
      t_enable();
      tally_and_finish();
   end
endmodule
`default_nettype wire
